// [rtl/breaker_failure_timing_logic.sv]
// breaker failure supervision: pick-up, blocking, retrip and failure timers, apb registers
// Behaviour
// (RULE1) blocking input is sampled once at each program cycle start and held.
// (RULE2) pick-up without blocking raises start and runs the delay timers.
// (RULE3) pick-up while blocked raises blocked; no timers, no trip outputs.
// (RULE4) blocking after start clears start and releases like pick-up drop.
// (RULE5) outside party presents blocking at least 5 ms before delay expiry.
// (RULE6) one pick-up condition starts both timers together.
// (RULE7) retrip delay plus breaker and release time should undercut failure delay.
// (RULE8) retrip enable, default on; off suppresses retrip and ignores its delay.
// (RULE9) retrip output after start persists retrip delay; 5 ms steps, 0.100 s.
// (RULE10) failure output after start persists failure delay; 5 ms steps, 0.200 s.
// (RULE11) readable condition: normal, start, retrip, failure, or blocked.
// (RULE12) current mode: any phase or residual over threshold picks up.
// (RULE13) current mode: timers reset once all currents are below threshold.
// (RULE14) current-and-trip mode: timers halt after pick-up until trip is active.
// (RULE15) current-and-trip mode: reset when currents drop or trip deasserts.
// (RULE16) current-or-trip mode: pick-up on current or trip, trip always watched.
// (RULE17) current-or-trip mode: reset only when currents low and trip inactive.
// (RULE18) a picked-up comparator releases below 97 % of its threshold.
// (RULE19) criterion select chooses which inputs drive pick-up.
// (RULE20) outputs fall when timers reset; next pick-up times from zero.
//
// Design decisions made here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ns
`include "bf_cfg.svh"
module breaker_failure_timing_logic
   import bf_pkg::*;
#(
   // shorter counts only to let a bench reach the delays quickly
   parameter int CYCLE_CYC = `BF_CYCLE_CYC,
   parameter int STEP_CYC = `BF_STEP_CYC
) (
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic [11:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic block_in,
   input wire logic primary_trip_in,
   output logic start_out,
   output logic blocked_out,
   output logic redundant_trip_out,
   output logic breaker_failure_output
);
   logic rst_meta_r;
   logic rst_n;
   logic blk_meta_r;
   logic blk_sync_r;
   logic trip_meta_r;
   logic trip_sync_r;
   logic cycle_tick;
   logic step_tick;
   logic [31:0] ctrl_r;
   logic [15:0] phase_pickup_threshold;
   logic [15:0] residual_pickup_threshold;
   logic [18:0] redundant_trip_delay;
   logic [18:0] bf_delay_r;
   logic [15:0] ph_cur_r [3];
   logic [15:0] res_cur_r;
   logic [3:0] cmp_r;
   logic blk_smp_r;
   logic pickup_r;
   logic [18:0] tmr_r;
   cond_e cond_r;
   logic cur_pick;
   logic trip_on;
   logic crit_pick;
   logic timer_run;
   logic timer_clr;
   logic rt_hit;
   logic bf_hit;
   logic rt_en;
   crit_e mode;
   logic apb_wr;
   logic apb_rd;
   logic [31:0] rd_nxt;
   logic rd_err_nxt;

   // over threshold, or at or above 97 % of it when already picked up
   function automatic logic cmp_next(input logic [15:0] cur, input logic [15:0] thr,
                                     input logic held);
      logic [23:0] lhs;
      logic [23:0] rhs;
      lhs = {8'h00, cur} * 24'(`BF_REL_DEN);
      rhs = {8'h00, thr} * 24'(`BF_REL_NUM);
      if (held)
         cmp_next = (lhs >= rhs); // RULE18
      else
         cmp_next = (cur > thr);
   endfunction

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         rst_meta_r <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_n <= rst_meta_r;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         blk_meta_r <= 1'b0;
         blk_sync_r <= 1'b0;
      end else begin
         blk_meta_r <= block_in;
         blk_sync_r <= blk_meta_r;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         trip_meta_r <= 1'b0;
         trip_sync_r <= 1'b0;
      end else begin
         trip_meta_r <= primary_trip_in;
         trip_sync_r <= trip_meta_r;
      end
   end

   bf_tick_div #(.N(CYCLE_CYC)) cycle_div (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .tick(cycle_tick)
   );

   // the delay step is a whole number of program cycles, so timing stays on cycle starts
   bf_tick_div #(.N(STEP_CYC)) step_div (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .tick(step_tick)
   );

   // apb: zero wait states, every access completes in its access phase
   assign apb_wr = psel && penable && pwrite;
   assign apb_rd = psel && !penable && !pwrite;

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_r <= `BF_CTRL_RST;
         phase_pickup_threshold <= `BF_PH_THR_RST;
         residual_pickup_threshold <= `BF_RES_THR_RST;
         redundant_trip_delay <= `BF_RT_DLY_RST;
         bf_delay_r <= `BF_BF_DLY_RST;
         ph_cur_r[0] <= 16'h0000;
         ph_cur_r[1] <= 16'h0000;
         ph_cur_r[2] <= 16'h0000;
         res_cur_r <= 16'h0000;
      end else if (apb_wr) begin
         case (paddr)
            `BF_OFS_CTRL: ctrl_r <= pwdata & 32'h0000_0131;
            `BF_OFS_PH_THR: phase_pickup_threshold <= pwdata[15:0];
            `BF_OFS_RES_THR: residual_pickup_threshold <= pwdata[15:0];
            `BF_OFS_RT_DLY: redundant_trip_delay <= pwdata[18:0];
            `BF_OFS_BF_DLY: bf_delay_r <= pwdata[18:0];
            `BF_OFS_PH_CUR0: ph_cur_r[0] <= pwdata[15:0];
            `BF_OFS_PH_CUR1: ph_cur_r[1] <= pwdata[15:0];
            `BF_OFS_PH_CUR2: ph_cur_r[2] <= pwdata[15:0];
            `BF_OFS_RES_CUR: res_cur_r <= pwdata[15:0];
            default: ;
         endcase
      end
   end

   always_comb begin
      rd_nxt = 32'h0000_0000;
      rd_err_nxt = 1'b0;
      case (paddr)
         `BF_OFS_CTRL: rd_nxt = ctrl_r;
         `BF_OFS_PH_THR: rd_nxt = {16'h0000, phase_pickup_threshold};
         `BF_OFS_RES_THR: rd_nxt = {16'h0000, residual_pickup_threshold};
         `BF_OFS_RT_DLY: rd_nxt = {13'h0000, redundant_trip_delay};
         `BF_OFS_BF_DLY: rd_nxt = {13'h0000, bf_delay_r};
         `BF_OFS_PH_CUR0: rd_nxt = {16'h0000, ph_cur_r[0]};
         `BF_OFS_PH_CUR1: rd_nxt = {16'h0000, ph_cur_r[1]};
         `BF_OFS_PH_CUR2: rd_nxt = {16'h0000, ph_cur_r[2]};
         `BF_OFS_RES_CUR: rd_nxt = {16'h0000, res_cur_r};
         `BF_OFS_STATUS: rd_nxt = {1'b0, tmr_r, 4'h0, cmp_r, 1'b0, 3'(cond_r)}; // RULE11
         default: rd_err_nxt = 1'b1;
      endcase
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel && !penable;
         pslverr <= psel && !penable && rd_err_nxt;
         if (apb_rd)
            prdata <= rd_nxt;
      end
   end

   assign mode = crit_e'(ctrl_r[`BF_CTRL_MODE_LSB +: `BF_CTRL_MODE_W]);
   assign rt_en = ctrl_r[`BF_CTRL_RT_EN_BIT];

   // comparators evaluate once per program cycle
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         cmp_r <= 4'h0;
      end else if (cycle_tick) begin
         for (int i = 0; i < 3; i++)
            cmp_r[i] <= cmp_next(ph_cur_r[i], phase_pickup_threshold, cmp_r[i]); // RULE12
         cmp_r[3] <= ctrl_r[`BF_CTRL_RES_EN_BIT] &&
                     cmp_next(res_cur_r, residual_pickup_threshold, cmp_r[3]); // RULE12
      end
   end

   assign cur_pick = |cmp_r;
   assign trip_on = trip_sync_r;

   // which inputs count as pick-up
   always_comb begin
      case (mode) // RULE19
         crit_current: crit_pick = cur_pick; // RULE12 RULE13
         crit_current_and_trip: crit_pick = cur_pick; // RULE14
         crit_current_or_trip: crit_pick = cur_pick || trip_on; // RULE16 RULE17
         default: crit_pick = cur_pick;
      endcase
   end

   // timers run only while picked up, unblocked and, in and-mode, trip present
   always_comb begin
      timer_clr = !pickup_r || blk_smp_r; // RULE4 RULE20
      case (mode)
         crit_current_and_trip: timer_run = !timer_clr && trip_on; // RULE14
         default: timer_run = !timer_clr;
      endcase
      if (mode == crit_current_and_trip && !trip_on)
         timer_clr = 1'b1; // RULE15
   end

   // blocking and pick-up are latched at each program cycle start
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         blk_smp_r <= 1'b0;
         pickup_r <= 1'b0;
      end else if (cycle_tick) begin
         blk_smp_r <= blk_sync_r; // RULE1
         pickup_r <= crit_pick;
      end
   end

   // in and-mode the timer holds at zero while waiting for the trip, which equals halted
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         tmr_r <= 19'h00000;
      end else if (timer_clr && !(mode == crit_current_and_trip && pickup_r && !blk_smp_r
                                  && !trip_on && tmr_r == 19'h00000)) begin
         tmr_r <= 19'h00000; // RULE13 RULE15 RULE17 RULE20
      end else if (timer_run && step_tick && tmr_r != 19'h7FFFF) begin
         tmr_r <= tmr_r + 19'h00001; // RULE6
      end
   end

   // one comparison feeds both the output and the readable condition
   function automatic logic delay_hit(input logic run, input logic [18:0] tmr,
                                      input logic [18:0] dly);
      delay_hit = run && (tmr >= dly);
   endfunction

   assign rt_hit = rt_en && delay_hit(timer_run, tmr_r, redundant_trip_delay); // RULE8 RULE9
   assign bf_hit = delay_hit(timer_run, tmr_r, bf_delay_r); // RULE10

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         start_out <= 1'b0;
         blocked_out <= 1'b0;
      end else begin
         start_out <= pickup_r && !blk_smp_r; // RULE2 RULE4
         blocked_out <= pickup_r && blk_smp_r; // RULE3
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         redundant_trip_out <= 1'b0;
      end else begin
         redundant_trip_out <= rt_hit; // RULE8 RULE9 RULE20
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         breaker_failure_output <= 1'b0;
      end else begin
         breaker_failure_output <= bf_hit; // RULE10 RULE20
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         cond_r <= cond_normal;
      end else begin
         if (pickup_r && blk_smp_r)
            cond_r <= cond_blocked; // RULE3
         else if (bf_hit)
            cond_r <= cond_bf_on;
         else if (rt_hit)
            cond_r <= cond_retrip;
         else if (pickup_r)
            cond_r <= cond_start;
         else
            cond_r <= cond_normal;
      end
   end
endmodule

// [rtl/bf_cfg.svh]
// offsets, field positions, reset values and timing counts of the breaker failure block
`ifndef BF_CFG_SVH
`define BF_CFG_SVH

// register byte offsets
`define BF_OFS_CTRL 12'h000
`define BF_OFS_PH_THR 12'h004
`define BF_OFS_RES_THR 12'h008
`define BF_OFS_RT_DLY 12'h00C
`define BF_OFS_BF_DLY 12'h010
`define BF_OFS_PH_CUR0 12'h014
`define BF_OFS_PH_CUR1 12'h018
`define BF_OFS_PH_CUR2 12'h01C
`define BF_OFS_RES_CUR 12'h020
`define BF_OFS_STATUS 12'h024

// control fields
`define BF_CTRL_RT_EN_BIT 0
`define BF_CTRL_MODE_LSB 4
`define BF_CTRL_MODE_W 2
`define BF_CTRL_RES_EN_BIT 8

// reset values; thresholds in 0.001 In units
`define BF_CTRL_RST 32'h0000_0101
`define BF_PH_THR_RST 16'h00C8
`define BF_RES_THR_RST 16'h04B0
// delays in 5 ms steps: 0.100 s and 0.200 s
`define BF_RT_DLY_RST 19'h00014
`define BF_BF_DLY_RST 19'h00028

// comparator release at 97 % of threshold
`define BF_REL_NUM 97
`define BF_REL_DEN 100

// timing
`define BF_CLK_HZ 100000000
`define BF_STEP_US 5000
`define BF_CYCLE_US 1000
`define BF_STEP_CYC (`BF_CLK_HZ / 1000000 * `BF_STEP_US)
`define BF_CYCLE_CYC (`BF_CLK_HZ / 1000000 * `BF_CYCLE_US)
`define BF_BLOCK_LEAD_MS 5

`endif

// [rtl/bf_pkg.sv]
// types of the breaker failure block
package bf_pkg;
   typedef enum logic [1:0] {
      crit_current,
      crit_current_and_trip,
      crit_current_or_trip,
      crit_reserved
   } crit_e;

   typedef enum logic [2:0] {
      cond_normal,
      cond_start,
      cond_retrip,
      cond_bf_on,
      cond_blocked
   } cond_e;
endpackage

// [rtl/bf_tick_div.sv]
// divider that issues a one-cycle enable every n system clocks
`timescale 1ns/1ns
module bf_tick_div #(
   parameter int N = 10
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   output logic tick
);
   logic [31:0] cnt_r;

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r <= 32'h0000_0000;
         tick <= 1'b0;
      end else if (cnt_r == 32'(N - 1)) begin
         cnt_r <= 32'h0000_0000;
         tick <= 1'b1;
      end else begin
         cnt_r <= cnt_r + 32'h0000_0001;
         tick <= 1'b0;
      end
   end
endmodule

// [test/bf_port_assertions.sv]
// port checker of the breaker failure block
`timescale 1ns/1ns
module bf_checker (
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic [11:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic block_in,
   input wire logic primary_trip_in,
   input wire logic start_out,
   input wire logic blocked_out,
   input wire logic redundant_trip_out,
   input wire logic breaker_failure_output
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   sequence setup_s;
      psel && !penable;
   endsequence
   sequence access_s;
      psel && penable;
   endsequence
   AST_APB_ZERO_WAIT: assert property (setup_s ##1 access_s |-> pready)
      else $error("pready late");
   AST_PREADY_PULSE: assert property (pready |-> access_s ##1 !pready)
      else $error("pready outside access");
   AST_SLVERR_QUAL: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   AST_START_BLOCK_EXCL: assert property (!(start_out && blocked_out))
      else $error("start and blocked together");
   AST_BLOCKED_NO_TRIP: assert property (blocked_out |->
      !redundant_trip_out && !breaker_failure_output)
      else $error("trip while blocked");
   AST_RELEASE_CLEARS: assert property ($fell(start_out) |->
      ##[0:2] (!redundant_trip_out && !breaker_failure_output))
      else $error("trip held after release");
   AST_RT_AFTER_START: assert property ($rose(redundant_trip_out) |->
      start_out || $past(start_out))
      else $error("retrip without start");
   AST_BF_AFTER_START: assert property ($rose(breaker_failure_output) |->
      start_out || $past(start_out))
      else $error("failure without start");
endmodule
bind breaker_failure_timing_logic bf_checker chk_u (.sys_clk, .rstn, .paddr, .psel, .penable,
   .pwrite, .pwdata, .prdata, .pready, .pslverr, .block_in, .primary_trip_in, .start_out,
   .blocked_out, .redundant_trip_out, .breaker_failure_output);

// [test/primary_trip_model.sv]
// primary protection trip contact seen by the block
`timescale 1ns/1ns
module primary_trip_model #(
   parameter int LAT = 3
) (
   input wire logic sys_clk,
   input wire logic trip_cmd,
   output logic primary_trip_in
);
   // contact closes and opens a few clocks after the command, like a relay
   logic [LAT-1:0] dly_r = '0;
   always_ff @(posedge sys_clk) begin
      dly_r <= {dly_r[LAT-2:0], trip_cmd};
   end
   assign primary_trip_in = dly_r[LAT-1];
endmodule

// [test/tb_breaker_failure_timing_logic.sv]
// self-checking bench of the breaker failure block
`timescale 1ns/1ns
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin err_count++; \
   $display("Error at %0t: got %h expected %h", $time, a, b); end end
module tb_breaker_failure_timing_logic;
   // scaled program cycle and delay step; the step stays a whole number of cycles
   localparam int TICK = 20;
   localparam int STEP = 100;
   localparam int LIM = 2 * TICK + 100;
   logic sys_clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, cur;
   logic pready, pslverr, block_in = 1'b0, trip_cmd = 1'b0, primary_trip_in;
   logic start_out, blocked_out, redundant_trip_out, breaker_failure_output;
   logic [3:0] outs;
   logic [64:0] e;
   logic [64:0] exp_q [$];
   logic [15:0] r = 16'h0002;
   logic [11:0] ch;
   int err_count = 0, samples_checked = 0;
   localparam logic [11:0] RA [5] = '{12'h000, 12'h004, 12'h008, 12'h00C, 12'h010};
   localparam logic [31:0] RV [5] = '{32'h101, 32'hC8, 32'h4B0, 32'h14, 32'h28};
   breaker_failure_timing_logic #(.CYCLE_CYC(TICK), .STEP_CYC(STEP)) dut_u (.sys_clk, .rstn,
      .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .block_in,
      .primary_trip_in, .start_out, .blocked_out, .redundant_trip_out, .breaker_failure_output);
   primary_trip_model #(.LAT(3)) prt_u (.sys_clk, .trip_cmd, .primary_trip_in);
   assign outs = {start_out, blocked_out, redundant_trip_out, breaker_failure_output};
   always #5 sys_clk = ~sys_clk;
   task automatic end_sim;
      if (err_count == 0 && samples_checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      input logic [31:0] m, input logic er);
      int n;
      exp_q.push_back({er, m, d & m});
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      psel <= 1'b0;
      penable <= 1'b0;
      // one idle edge, so a following call never reassigns psel in this step
      @(posedge sys_clk);
   endtask
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task automatic wait_outs(input logic [3:0] x, input int lim);
      int n;
      n = 0;
      while (outs !== x && n < lim) begin
         @(posedge sys_clk);
         n++;
      end
      `CHK(outs, x)
   endtask
   // random current always above the 200 threshold, on a random phase
   task automatic cur_up;
      r = lfsr(r);
      cur = 32'h0100 | {20'h0, r[11:0]};
      ch = 12'h014 + 12'(4 * (r % 3));
      apb(1'b1, ch, cur, '0, 1'b0);
   endtask
   always @(posedge sys_clk) begin
      if (psel && penable && pready) begin
         e = exp_q.pop_front();
         `CHK({pslverr, prdata & e[63:32]}, {e[64], e[31:0]})
      end
   end
   initial begin
      // far beyond the nine hundred or so cycles the scenarios need
      #500_000;
      err_count++;
      end_sim();
   end
   initial begin
      repeat (10) @(posedge sys_clk);
      rstn <= 1'b1;
      repeat (3) @(posedge sys_clk);
      for (int i = 0; i < 5; i++) apb(1'b0, RA[i], RV[i], '1, 1'b0);
      apb(1'b0, 12'h028, '0, '1, 1'b1);
      apb(1'b1, 12'h028, 32'h5A, '0, 1'b1);
      apb(1'b1, 12'h00C, '0, '0, 1'b0);
      apb(1'b1, 12'h010, '0, '0, 1'b0);
      cur_up();
      wait_outs(4'b1011, LIM);
      apb(1'b0, 12'h024, 32'h3, 32'h7, 1'b0);
      apb(1'b1, ch, 32'd195, '0, 1'b0);
      repeat (2 * TICK) @(posedge sys_clk);
      `CHK(outs, 4'b1011)
      apb(1'b1, ch, '0, '0, 1'b0);
      wait_outs(4'b0000, LIM);
      apb(1'b0, 12'h024, 32'h0, 32'h7, 1'b0);
      apb(1'b1, 12'h000, 32'h100, '0, 1'b0);
      cur_up();
      wait_outs(4'b1001, LIM);
      apb(1'b1, 12'h000, 32'h101, '0, 1'b0);
      wait_outs(4'b1011, LIM);
      // blocking raised while tripped must withdraw start and both trips and raise blocked
      block_in <= 1'b1;
      wait_outs(4'b0100, LIM);
      apb(1'b0, 12'h024, 32'h4, 32'h7, 1'b0);
      apb(1'b1, ch, '0, '0, 1'b0);
      block_in <= 1'b0;
      wait_outs(4'b0000, LIM);
      // blocking present well ahead of any delay expiry
      block_in <= 1'b1;
      repeat (2 * TICK) @(posedge sys_clk);
      cur_up();
      wait_outs(4'b0100, LIM);
      repeat (STEP) @(posedge sys_clk);
      `CHK(outs, 4'b0100)
      apb(1'b1, ch, '0, '0, 1'b0);
      wait_outs(4'b0000, LIM);
      block_in <= 1'b0;
      apb(1'b1, 12'h000, 32'h111, '0, 1'b0);
      apb(1'b1, 12'h00C, 32'h1, '0, 1'b0);
      apb(1'b1, 12'h010, 32'h1, '0, 1'b0);
      cur_up();
      wait_outs(4'b1000, LIM);
      repeat (STEP + 2 * TICK) @(posedge sys_clk);
      `CHK(outs, 4'b1000)
      trip_cmd <= 1'b1;
      wait_outs(4'b1011, STEP + LIM);
      trip_cmd <= 1'b0;
      wait_outs(4'b1000, LIM);
      apb(1'b1, ch, '0, '0, 1'b0);
      apb(1'b1, 12'h000, 32'h121, '0, 1'b0);
      apb(1'b1, 12'h00C, '0, '0, 1'b0);
      apb(1'b1, 12'h010, '0, '0, 1'b0);
      wait_outs(4'b0000, LIM);
      trip_cmd <= 1'b1;
      wait_outs(4'b1011, LIM);
      cur_up();
      // let the current comparator pick up before the trip goes away
      repeat (2 * TICK) @(posedge sys_clk);
      `CHK(outs, 4'b1011)
      trip_cmd <= 1'b0;
      repeat (2 * TICK) @(posedge sys_clk);
      `CHK(outs, 4'b1011)
      apb(1'b1, ch, '0, '0, 1'b0);
      wait_outs(4'b0000, LIM);
      end_sim();
   end
endmodule
